// ### core/xcvr_cfg_pkg.sv
package xcvr_cfg_pkg;
    // Register port widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [3:0] ADDR_CLOCK_OUTPUT_CONFIG = 4'h9;
    localparam logic [3:0] ADDR_CLOCK_FREQUENCY_TRIM = 4'hA;
    localparam logic [3:0] ADDR_MASTER_LINE_CONFIG = 4'hB;
    localparam logic [3:0] ADDR_REVISION_IDENTIFIER = 4'hC;
    localparam logic [3:0] ADDR_THERMAL_CONVERTER_CONFIG = 4'hD;
    localparam logic [3:0] ADDR_THERMAL_RESULT = 4'hF;

    // Reset value shared by every writable register
    localparam logic [7:0] RESET_CONFIG = 8'h00;

    // Clock output config fields
    localparam int TRIM_ENABLE_BIT = 7;
    localparam int DIV_LSB = 1;
    localparam int DIV_W = 3;
    localparam int CLOCK_DISABLE_BIT = 0;
    // Trim field
    localparam int TRIM_LSB = 0;
    localparam int TRIM_W = 6;
    // Master line config fields
    localparam int WAKEUP_REQUEST_BIT = 7;
    localparam int RX_THRESHOLD_BIT = 4;
    localparam int CURRENT_HIGH_BIT = 1;
    localparam int CURRENT_LOW_BIT = 0;
    // Thermal config and result fields
    localparam int CONV_START_BIT = 7;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 2;
    localparam int MODE_MANUAL_BIT = 1;
    localparam int CONV_BUSY_BIT = 7;
    localparam int TEMP_LSB = 0;
    localparam int TEMP_W = 6;

    // Divider codes
    localparam logic [2:0] DIV_3M686 = 3'h0;
    localparam logic [2:0] DIV_7M373 = 3'h1;
    localparam logic [2:0] DIV_14M74 = 3'h2;
    localparam logic [2:0] DIV_29M49 = 3'h3;
    localparam logic [2:0] DIV_1M843 = 3'h4;
    // Thermal modes
    localparam logic [1:0] MODE_PROGRAMMABLE = 2'h1;

    // Timing
    localparam longint CLK_HZ = 10000000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int WAKEUP_PULSE_NS = 80000;
    localparam int WAKE_CNT_W = 10;
    localparam logic [9:0] WAKEUP_PULSE_CYCLES = 10'(WAKEUP_PULSE_NS / CLK_PERIOD_NS);

    // Phase accumulator for the clock output
    localparam int NCO_W = 28;
    localparam longint MCLK_BASE_HZ = 3686000;
    localparam logic [27:0] NCO_BASE_INC = 28'((MCLK_BASE_HZ << NCO_W) / CLK_HZ);
    // Trim slope per code, Q16 fraction of nominal
    localparam int TRIM_FRAC_W = 16;
    localparam logic [7:0] TRIM_NEG_SLOPE_Q16 = 8'h66;
    localparam logic [7:0] TRIM_POS_SLOPE_Q16 = 8'h8E;

    // One-hot state codes
    typedef enum logic [1:0] {
        WAKE_IDLE = 2'b01,
        WAKE_PULSE = 2'b10
    } wake_state_t;
    typedef enum logic [2:0] {
        CONV_IDLE = 3'b001,
        CONV_START = 3'b010,
        CONV_WAIT = 3'b100
    } conv_state_t;
endpackage

// ### core/clock_output_nco.sv
`timescale 1ns/10ps
module clock_output_nco (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Frequency control
    input wire logic [xcvr_cfg_pkg::DIV_W-1:0] divider_select,
    input wire logic signed [xcvr_cfg_pkg::TRIM_W-1:0] trim,
    input wire logic output_disable,
    // Clock output
    output logic mclk
);
    import xcvr_cfg_pkg::*;

    localparam int PROD_W = NCO_W + TRIM_W + 10;

    logic [NCO_W-1:0] base_inc; // Increment before trim
    logic [NCO_W-1:0] step_inc; // Increment after trim
    logic [NCO_W-1:0] phase; // Accumulator
    logic [NCO_W-1:0] next_phase;
    logic next_mclk;
    logic signed [8:0] slope; // Slope differs per sign of trim
    logic signed [PROD_W-1:0] trim_product;

    // Divider select and trim give the phase step.
    // Rates above half of CLK alias; the real part uses an analog oscillator.
    always_comb begin
        case (divider_select)
            DIV_7M373: base_inc = NCO_W'(NCO_BASE_INC << 1);
            DIV_14M74: base_inc = NCO_W'(NCO_BASE_INC << 2);
            DIV_29M49: base_inc = NCO_W'(NCO_BASE_INC << 3);
            DIV_1M843: base_inc = NCO_W'(NCO_BASE_INC >> 1);
            default: base_inc = NCO_BASE_INC; // Undefined codes fall back to nominal
        endcase
        slope = trim[TRIM_W-1] ? $signed({1'b0, TRIM_NEG_SLOPE_Q16}) : $signed({1'b0, TRIM_POS_SLOPE_Q16});
        trim_product = $signed({1'b0, base_inc}) * trim * slope;
        step_inc = base_inc + NCO_W'(trim_product >>> TRIM_FRAC_W);
        next_phase = phase + step_inc;
        next_mclk = output_disable ? 1'b1 : phase[NCO_W-1];
    end

    // Registers only
    always_ff @(posedge clk) begin
        if (rst) begin
            phase <= '0;
            mclk <= 1'b1;
        end else begin
            phase <= next_phase;
            mclk <= next_mclk;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_DISABLE_HIGH:
        assert property (output_disable ##1 output_disable |=> mclk)
        else $error("clock output not high while disabled");
    AST_HALF_RATE:
        assert property ((divider_select == DIV_1M843) && (trim == 0) |-> step_inc == (NCO_BASE_INC >> 1))
        else $error("half rate step wrong");
    AST_TRIM_SIGN:
        assert property ((divider_select == DIV_3M686) && (trim != 0)
                         |-> (trim[TRIM_W-1] ? step_inc < base_inc : step_inc > base_inc))
        else $error("trim moved frequency the wrong way");
endmodule // clock_output_nco

// ### core/clock_wakeup_thermal_config_regs.sv
// Overview of operation
// - Trim enable applies trim value to clock
// - Divider field picks clock output frequency
// - Power-up clock runs at default rate
// - Disable bit stops clock, holds high
// - Trim field is signed, centred on zero
// - Wake-up request drives one 80us pulse
// - Wake-up request bit self clears
// - Threshold bit picks line or TTL levels
// - Bit 1 enables high line current
// - Bit 0 enables low line current
// - Read-only revision identifier, writes ignored
// - Start bit begins manual conversion in 1x
// - Finished conversion writes thermal result
// - Start bit self clears on completion
// - Mode field selects thermal warning behaviour
// - Result busy flag shows conversion running
// - Result code 3C per step, zero at -15C
// - Push-pull select puts driver push-pull
`timescale 1ns/10ps
module clock_wakeup_thermal_config_regs #(
    parameter logic [7:0] REVISION_ID = 8'h5A // Arbitrary value
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Register port
    input wire logic [xcvr_cfg_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [xcvr_cfg_pkg::DATA_W-1:0] REG_WDATA,
    output logic [xcvr_cfg_pkg::DATA_W-1:0] REG_RDATA,
    // Host clock output
    output logic MCLK,
    // Line driver and receiver controls
    input wire logic PUSH_PULL_SELECT,
    output logic LINE_PUSH_PULL,
    output logic WAKEUP_PULSE,
    output logic RECEIVER_THRESHOLD_SELECT,
    output logic LINE_CURRENT_HIGH_ENABLE,
    output logic LINE_CURRENT_LOW_ENABLE,
    // Thermal converter
    output logic THERMAL_CONV_START,
    input wire logic THERMAL_CONV_DONE,
    input wire logic [xcvr_cfg_pkg::TEMP_W-1:0] THERMAL_CONV_CODE,
    output logic THERMAL_WARNING_ENABLE,
    output logic THERMAL_PROG_THRESHOLD
);
    import xcvr_cfg_pkg::*;

    // Configuration state and next values
    logic trim_enable, next_trim_enable;
    logic [DIV_W-1:0] clock_divider_select, next_clock_divider_select;
    logic clock_output_disable, next_clock_output_disable;
    logic [TRIM_W-1:0] frequency_trim, next_frequency_trim;
    logic [MODE_W-1:0] thermal_mode_select, next_thermal_mode_select;
    logic next_rx_threshold, next_current_high, next_current_low, next_push_pull; // Feed output flops
    logic [TRIM_W-1:0] applied_trim; // Trim seen by the oscillator
    // Wake-up pulse state
    wake_state_t wake_state, next_wake_state;
    logic [WAKE_CNT_W-1:0] wake_count, next_wake_count;
    logic wake_start; // Write of 1 to the request bit
    // Conversion state
    conv_state_t conv_state, next_conv_state;
    logic [TEMP_W-1:0] temperature_value, next_temperature_value;
    logic conv_request; // Start accepted only in manual mode
    logic conv_busy;
    // Read path and write decodes
    logic [DATA_W-1:0] next_rdata;
    logic wr_clock, wr_trim, wr_line, wr_thermal;
    assign wr_clock = REG_WR && (REG_ADDR == ADDR_CLOCK_OUTPUT_CONFIG);
    assign wr_trim = REG_WR && (REG_ADDR == ADDR_CLOCK_FREQUENCY_TRIM);
    assign wr_line = REG_WR && (REG_ADDR == ADDR_MASTER_LINE_CONFIG);
    assign wr_thermal = REG_WR && (REG_ADDR == ADDR_THERMAL_CONVERTER_CONFIG);
    assign wake_start = wr_line && REG_WDATA[WAKEUP_REQUEST_BIT];
    // start only while mode is 1x
    assign conv_request = wr_thermal && REG_WDATA[CONV_START_BIT] && REG_WDATA[MODE_LSB + MODE_MANUAL_BIT];
    assign conv_busy = (conv_state != CONV_IDLE);

    // Plain configuration fields; reserved bits are never stored
    always_comb begin
        next_trim_enable = trim_enable;
        next_clock_divider_select = clock_divider_select;
        next_clock_output_disable = clock_output_disable;
        next_frequency_trim = frequency_trim;
        next_rx_threshold = RECEIVER_THRESHOLD_SELECT;
        next_current_high = LINE_CURRENT_HIGH_ENABLE;
        next_current_low = LINE_CURRENT_LOW_ENABLE;
        next_thermal_mode_select = thermal_mode_select;
        next_push_pull = PUSH_PULL_SELECT;
        if (wr_clock) begin
            next_trim_enable = REG_WDATA[TRIM_ENABLE_BIT];
            next_clock_divider_select = REG_WDATA[DIV_LSB +: DIV_W];
            next_clock_output_disable = REG_WDATA[CLOCK_DISABLE_BIT];
        end
        if (wr_trim) begin
            next_frequency_trim = REG_WDATA[TRIM_LSB +: TRIM_W];
        end
        if (wr_line) begin
            next_rx_threshold = REG_WDATA[RX_THRESHOLD_BIT];
            next_current_high = REG_WDATA[CURRENT_HIGH_BIT];
            next_current_low = REG_WDATA[CURRENT_LOW_BIT];
        end
        if (wr_thermal) begin
            next_thermal_mode_select = REG_WDATA[MODE_LSB +: MODE_W];
        end
    end
    // Configuration registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            trim_enable <= RESET_CONFIG[TRIM_ENABLE_BIT];
            clock_divider_select <= RESET_CONFIG[DIV_LSB +: DIV_W];
            clock_output_disable <= RESET_CONFIG[CLOCK_DISABLE_BIT];
            frequency_trim <= RESET_CONFIG[TRIM_LSB +: TRIM_W];
            RECEIVER_THRESHOLD_SELECT <= RESET_CONFIG[RX_THRESHOLD_BIT];
            LINE_CURRENT_HIGH_ENABLE <= RESET_CONFIG[CURRENT_HIGH_BIT];
            LINE_CURRENT_LOW_ENABLE <= RESET_CONFIG[CURRENT_LOW_BIT];
            thermal_mode_select <= RESET_CONFIG[MODE_LSB +: MODE_W];
            THERMAL_WARNING_ENABLE <= 1'b1;
            THERMAL_PROG_THRESHOLD <= 1'b0;
            LINE_PUSH_PULL <= 1'b0;
        end else begin
            trim_enable <= next_trim_enable;
            clock_divider_select <= next_clock_divider_select;
            clock_output_disable <= next_clock_output_disable;
            frequency_trim <= next_frequency_trim;
            RECEIVER_THRESHOLD_SELECT <= next_rx_threshold;
            LINE_CURRENT_HIGH_ENABLE <= next_current_high;
            LINE_CURRENT_LOW_ENABLE <= next_current_low;
            thermal_mode_select <= next_thermal_mode_select;
            THERMAL_WARNING_ENABLE <= !next_thermal_mode_select[MODE_MANUAL_BIT];
            THERMAL_PROG_THRESHOLD <= (next_thermal_mode_select == MODE_PROGRAMMABLE);
            LINE_PUSH_PULL <= next_push_pull;
        end
    end
    assign applied_trim = trim_enable ? frequency_trim : '0;
    // Oscillator model for the host clock
    clock_output_nco u_nco (
        .clk(CLK),
        .rst(RST),
        .divider_select(clock_divider_select),
        .trim(applied_trim),
        .output_disable(clock_output_disable),
        .mclk(MCLK)
    );
    // Wake-up pulse sequencer.
    // A repeat request mid-pulse is absorbed; on the last cycle it wins
    // over the self clear and starts a fresh pulse.
    always_comb begin
        next_wake_state = wake_state;
        next_wake_count = wake_count;
        case (wake_state)
            WAKE_IDLE: begin
                if (wake_start) begin
                    next_wake_state = WAKE_PULSE;
                    next_wake_count = '0;
                end
            end
            WAKE_PULSE: begin
                if (wake_count == WAKEUP_PULSE_CYCLES - 10'h001) begin
                    next_wake_count = '0;
                    next_wake_state = wake_start ? WAKE_PULSE : WAKE_IDLE;
                end else begin
                    next_wake_count = wake_count + 10'h001;
                end
            end
            default: begin
                next_wake_state = WAKE_IDLE;
                next_wake_count = '0;
            end
        endcase
    end
    // Wake-up registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            wake_state <= WAKE_IDLE;
            wake_count <= '0;
        end else begin
            wake_state <= next_wake_state;
            wake_count <= next_wake_count;
        end
    end
    // Pulse pin is the one-hot state bit itself
    assign WAKEUP_PULSE = wake_state[1];
    // Manual conversion sequencer; a start while busy is ignored unless it comes with done, which starts a fresh conversion
    always_comb begin
        next_conv_state = conv_state;
        next_temperature_value = temperature_value;
        case (conv_state)
            CONV_IDLE: begin
                if (conv_request) begin
                    next_conv_state = CONV_START;
                end
            end
            CONV_START: next_conv_state = CONV_WAIT;
            CONV_WAIT: begin
                if (THERMAL_CONV_DONE) begin
                    next_temperature_value = THERMAL_CONV_CODE;
                    next_conv_state = conv_request ? CONV_START : CONV_IDLE;
                end
            end
            default: next_conv_state = CONV_IDLE;
        endcase
    end
    // Conversion registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            conv_state <= CONV_IDLE;
            temperature_value <= '0;
        end else begin
            conv_state <= next_conv_state;
            temperature_value <= next_temperature_value;
        end
    end
    // Start strobe is the one-hot start bit
    assign THERMAL_CONV_START = conv_state[1];
    // Read mux; reserved and unmapped bits read zero
    always_comb begin
        next_rdata = '0;
        case (REG_ADDR)
            ADDR_CLOCK_OUTPUT_CONFIG: begin
                next_rdata[TRIM_ENABLE_BIT] = trim_enable;
                next_rdata[DIV_LSB +: DIV_W] = clock_divider_select;
                next_rdata[CLOCK_DISABLE_BIT] = clock_output_disable;
            end
            ADDR_CLOCK_FREQUENCY_TRIM: next_rdata[TRIM_LSB +: TRIM_W] = frequency_trim;
            ADDR_MASTER_LINE_CONFIG: begin
                next_rdata[WAKEUP_REQUEST_BIT] = WAKEUP_PULSE;
                next_rdata[RX_THRESHOLD_BIT] = RECEIVER_THRESHOLD_SELECT;
                next_rdata[CURRENT_HIGH_BIT] = LINE_CURRENT_HIGH_ENABLE;
                next_rdata[CURRENT_LOW_BIT] = LINE_CURRENT_LOW_ENABLE;
            end
            ADDR_REVISION_IDENTIFIER: begin
                next_rdata = REVISION_ID;
            end
            ADDR_THERMAL_CONVERTER_CONFIG: begin
                next_rdata[CONV_START_BIT] = conv_busy;
                next_rdata[MODE_LSB +: MODE_W] = thermal_mode_select;
            end
            ADDR_THERMAL_RESULT: begin
                next_rdata[CONV_BUSY_BIT] = conv_busy;
                next_rdata[TEMP_LSB +: TEMP_W] = temperature_value;
            end
            default: next_rdata = '0;
        endcase
    end
    // Read data register, holds until next read
    always_ff @(posedge CLK) begin
        if (RST) begin
            REG_RDATA <= '0;
        end else if (REG_RD) begin
            REG_RDATA <= next_rdata;
        end
    end
    // Pulse length helper for checking only
    logic [10:0] pulse_len;
    always_ff @(posedge CLK) begin
        if (RST) begin
            pulse_len <= '0;
        end else if (wake_start && (next_wake_count == '0) && (next_wake_state == WAKE_PULSE)) begin
            pulse_len <= '0;
        end else if (WAKEUP_PULSE) begin
            pulse_len <= pulse_len + 11'h001;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // Reset disables checks, so look at the release edge
    AST_RESET_DEFAULT_CLOCK:
        assert property ($fell(RST) |-> (clock_divider_select == DIV_3M686) && !clock_output_disable && !trim_enable)
        else $error("clock not at default after reset");
    AST_TRIM_GATED:
        assert property (!trim_enable && !wr_clock |=> u_nco.trim == '0)
        else $error("trim applied while disabled");
    AST_WAKE_LENGTH:
        assert property ($fell(WAKEUP_PULSE) |-> pulse_len == {1'b0, WAKEUP_PULSE_CYCLES})
        else $error("wake-up pulse length wrong");
    AST_WAKE_START:
        assert property (wake_start && !WAKEUP_PULSE |=> WAKEUP_PULSE [*8])
        else $error("wake-up pulse did not start");
    AST_WAKE_SELF_CLEAR:
        assert property (REG_RD && (REG_ADDR == ADDR_MASTER_LINE_CONFIG) && !WAKEUP_PULSE
                         |=> !REG_RDATA[WAKEUP_REQUEST_BIT])
        else $error("wake-up request bit not cleared");
    AST_RX_THRESHOLD:
        assert property (wr_line |=> RECEIVER_THRESHOLD_SELECT == $past(REG_WDATA[RX_THRESHOLD_BIT]))
        else $error("threshold select not stored");
    AST_CURRENT_HIGH:
        assert property (wr_line |=> LINE_CURRENT_HIGH_ENABLE == $past(REG_WDATA[CURRENT_HIGH_BIT]))
        else $error("high current enable not stored");
    AST_CURRENT_LOW:
        assert property (wr_line |=> LINE_CURRENT_LOW_ENABLE == $past(REG_WDATA[CURRENT_LOW_BIT]))
        else $error("low current enable not stored");
    AST_REVISION_READ:
        assert property (REG_RD && (REG_ADDR == ADDR_REVISION_IDENTIFIER) |=> REG_RDATA == REVISION_ID)
        else $error("revision identifier wrong");
    AST_CONV_START:
        assert property (conv_request && !conv_busy |=> THERMAL_CONV_START ##1 !THERMAL_CONV_START)
        else $error("conversion start strobe wrong");
    AST_CONV_RESULT:
        assert property (conv_state == CONV_WAIT && THERMAL_CONV_DONE
                         |=> temperature_value == $past(THERMAL_CONV_CODE))
        else $error("conversion result not captured");
    AST_CONV_CLEAR:
        assert property (conv_state == CONV_WAIT && THERMAL_CONV_DONE && !conv_request |=> !conv_busy)
        else $error("start bit not cleared on completion");
    AST_MODE_WARNING:
        assert property (wr_thermal |=> THERMAL_WARNING_ENABLE == !$past(REG_WDATA[MODE_LSB + MODE_MANUAL_BIT]))
        else $error("thermal warning mode wrong");
    AST_BUSY_FLAG:
        assert property (REG_RD && (REG_ADDR == ADDR_THERMAL_RESULT) |=> REG_RDATA[CONV_BUSY_BIT] == $past(conv_busy))
        else $error("busy flag wrong");
    AST_RESERVED_ZERO:
        assert property (REG_RD && (REG_ADDR == ADDR_CLOCK_FREQUENCY_TRIM) |=> REG_RDATA[DATA_W-1:TRIM_W] == '0)
        else $error("reserved bits not zero");
    COV_WAKE_DONE: cover property ($fell(WAKEUP_PULSE));
    COV_CONV_DONE: cover property (conv_state == CONV_WAIT && THERMAL_CONV_DONE);
    COV_CLOCK_OFF: cover property (clock_output_disable && MCLK);
endmodule // clock_wakeup_thermal_config_regs

// ### test/xcvr_host_model.sv
`timescale 1ns/10ps
module xcvr_host_model (
    // Clock
    input wire logic clk,
    // Register port
    output logic [3:0] addr,
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata,
    // Driver mode
    output logic pp
);
    // Idle port at time zero
    initial begin
        addr = 4'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        wdata = 8'h00;
        pp = 1'b0;
    end
    // Data inverted after the strobe so a late sample fails
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) #10;
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(posedge clk) #10;
        wr_en = 1'b0;
        wdata = ~d;
    endtask
    // Read data is taken at the edge after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk) #10;
        addr = a;
        rd_en = 1'b1;
        @(posedge clk) #10;
        rd_en = 1'b0;
        d = rdata;
    endtask
    task automatic wake();
        pp = 1'b1;
        wr(4'hB, 8'h80);
    endtask
endmodule // xcvr_host_model

// ### test/clock_wakeup_thermal_config_regs_tb_top.sv
`timescale 1ns/10ps
module clock_wakeup_thermal_config_regs_tb_top;
    import xcvr_cfg_pkg::*;
    // Arbitrary revision value
    localparam logic [7:0] REV = 8'hC3;
    // Design pins
    logic clk, rst, wr_en, rd_en, pp, mclk, lpp, wake, rxsel, chi, clo, cst, cdone, twarn, tprog;
    logic [3:0] addr, a;
    logic [7:0] wdata, rdata, v, d;
    logic [5:0] ccode, code;
    // Bench state and setting tables
    int seed, miscompares, n_checks, cyc, n;
    logic [3:0] atab [4] = '{4'h9, 4'hA, 4'hB, 4'hD};
    logic [7:0] ctab [6] = '{8'h00, 8'h08, 8'h80, 8'h00, 8'h80, 8'h01};
    logic [7:0] ttab [6] = '{8'h00, 8'h00, 8'h20, 8'h20, 8'h1F, 8'h00};
    int etab [6] = '{737, 369, 700, 737, 786, 0};

    clock_wakeup_thermal_config_regs #(.REVISION_ID(REV)) dut (
        .CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr_en), .REG_RD(rd_en), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .MCLK(mclk), .PUSH_PULL_SELECT(pp), .LINE_PUSH_PULL(lpp), .WAKEUP_PULSE(wake),
        .RECEIVER_THRESHOLD_SELECT(rxsel), .LINE_CURRENT_HIGH_ENABLE(chi), .LINE_CURRENT_LOW_ENABLE(clo),
        .THERMAL_CONV_START(cst), .THERMAL_CONV_DONE(cdone), .THERMAL_CONV_CODE(ccode),
        .THERMAL_WARNING_ENABLE(twarn), .THERMAL_PROG_THRESHOLD(tprog));
    xcvr_host_model host (.clk(clk), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata),
        .rdata(rdata), .pp(pp));

    // Writable bits of each register
    function automatic logic [7:0] wmask(input logic [3:0] r);
        case (r)
            4'h9: return 8'h8F;
            4'hA: return 8'h3F;
            4'hB: return 8'h93;
            default: return 8'h83;
        endcase
    endfunction
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", s, e, g);
            miscompares++;
        end
    endtask
    task automatic rchk(input logic [3:0] r, input logic [7:0] e);
        host.rd(r, v);
        chk($sformatf("reg %h", r), {8'h00, e}, {8'h00, v});
    endtask
    // Clock output transitions over k cycles
    task automatic tog(input int k, output int c);
        logic p;
        c = 0;
        p = mclk;
        repeat (k) begin
            @(posedge clk) #10;
            c += int'(mclk != p);
            p = mclk;
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Hang guard, well above the expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        seed = 32'h888F;
        rst = 1'b1;
        cdone = 1'b0;
        ccode = 6'h00;
        code = 6'h00;
        repeat (8) @(posedge clk);
        #10;
        rst = 1'b0;
        // Every address, unmapped included
        for (int i = 0; i < 16; i++) begin
            rchk(4'(i), (i == 12) ? REV : 8'h00);
        end
        host.wr(ADDR_REVISION_IDENTIFIER, 8'h00);
        rchk(ADDR_REVISION_IDENTIFIER, REV);
        // Random writes, request bits kept clear
        repeat (24) begin
            a = atab[2'($random(seed))];
            d = 8'($random(seed));
            d[7] = d[7] & (a < 4'hB);
            host.wr(a, d);
            rchk(a, d & wmask(a));
            if (a == ADDR_MASTER_LINE_CONFIG) begin
                chk("line", {13'h0, d[4], d[1:0]}, {13'h0, rxsel, chi, clo});
            end
            if (a == ADDR_THERMAL_CONVERTER_CONFIG) begin
                chk("mode", {14'h0, ~d[1], d[1:0] == 2'h1}, {14'h0, twarn, tprog});
            end
        end
        // Rate per setting, within three transitions
        for (int i = 0; i < 6; i++) begin
            host.wr(ADDR_CLOCK_FREQUENCY_TRIM, ttab[i]);
            host.wr(ADDR_CLOCK_OUTPUT_CONFIG, ctab[i]);
            tog(1000, n);
            chk("mclk", 16'(etab[i]), (n > etab[i] - 4 && n < etab[i] + 4) ? 16'(etab[i]) : 16'(n));
        end
        chk("mclk high", 16'h1, {15'h0, mclk});
        // Pulse length; the read spends two cycles
        host.wake();
        rchk(ADDR_MASTER_LINE_CONFIG, 8'h80);
        n = 0;
        while (wake === 1'b1 && n < 2000) begin
            n++;
            @(posedge clk) #10;
        end
        chk("wake", 16'd798, 16'(n));
        rchk(ADDR_MASTER_LINE_CONFIG, 8'h00);
        chk("pp", 16'h1, {15'h0, lpp});
        // Start refused in a warning mode
        host.wr(ADDR_THERMAL_CONVERTER_CONFIG, 8'h80);
        chk("start", 16'h0, {15'h0, cst});
        rchk(ADDR_THERMAL_CONVERTER_CONFIG, 8'h00);
        // One conversion in each manual mode, the second after the first completes
        for (int m = 2; m < 4; m++) begin
            host.wr(ADDR_THERMAL_CONVERTER_CONFIG, 8'h80 | 8'(m));
            chk("start", 16'h1, {15'h0, cst});
            rchk(ADDR_THERMAL_RESULT, {2'b10, code});
            chk("start", 16'h0, {14'h0, cst, twarn});
            rchk(ADDR_THERMAL_CONVERTER_CONFIG, 8'h80 | 8'(m));
            code = 6'($random(seed));
            repeat (2'($random(seed))) @(posedge clk);
            @(posedge clk) #10;
            cdone = 1'b1;
            ccode = code;
            @(posedge clk) #10;
            cdone = 1'b0;
            ccode = ~code;
            rchk(ADDR_THERMAL_RESULT, {2'b00, code});
            rchk(ADDR_THERMAL_CONVERTER_CONFIG, 8'(m));
        end
        test_done();
    end
endmodule // clock_wakeup_thermal_config_regs_tb_top
